// File: rtl/csw_pkg.sv
// Purpose: Shared constants and types for the clock switch and reference output block.
// Assumes: AHB-Lite register access, 32-bit data, one register per aligned word.
// Notes: Offsets are byte addresses.

`default_nettype none

package csw_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] OFS_OSC_CTRL = 8'h00;
  localparam logic [7:0] OFS_REF_CTRL = 8'h04;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
  localparam logic [7:0] OFS_OSC_STAT = 8'h10;

  // ==========================================================================
  // Unlock keys
  localparam logic [7:0] KEY_HI_1 = 8'h78;
  localparam logic [7:0] KEY_HI_2 = 8'h9A;
  localparam logic [7:0] KEY_LO_1 = 8'h46;
  localparam logic [7:0] KEY_LO_2 = 8'h57;

  // ==========================================================================
  // Oscillator control fields
  localparam int NEW_SOURCE_SELECT_LSB = 8;
  localparam int NEW_SOURCE_SELECT_W = 3;
  localparam int SWEN_BIT = 0;
  localparam int COSC_LSB = 12;

  // Reference control fields
  localparam int REF_EN_BIT = 15;
  localparam int REF_SLP_BIT = 13;
  localparam int REF_SEL_BIT = 12;
  localparam int REF_DIV_LSB = 8;
  localparam int REF_DIV_W = 4;

  // Interrupt status bits
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_FAIL_BIT = 1;
  localparam int IRQ_W = 2;

  // Status register bits
  localparam int STAT_LOCK_BIT = 0;
  localparam int STAT_RDY_BIT = 1;

  // ==========================================================================
  // Reset values and timing
  localparam logic [15:0] REF_CTRL_RST = 16'h0000;
  localparam logic [NEW_SOURCE_SELECT_W-1:0] SRC_RST = 3'h0;
  localparam int SWITCH_TIMEOUT_US = 20;
  localparam int CLK_MHZ = 250;
  localparam int SWITCH_TIMEOUT_CYC = SWITCH_TIMEOUT_US * CLK_MHZ;

  // Source codes that count as primary modes.
  localparam logic [NEW_SOURCE_SELECT_W-1:0] SRC_PRI_EC = 3'h2;
  localparam logic [NEW_SOURCE_SELECT_W-1:0] SRC_PRI_XT = 3'h3;
  localparam logic [NEW_SOURCE_SELECT_W-1:0] SRC_PRI_HS = 3'h4;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    SW_IDLE = 3'b001,
    SW_WAIT = 3'b010,
    SW_FAIL = 3'b100
  } csw_state_t;

  typedef enum logic [3:0] {
    UL_NONE = 4'b0001,
    UL_HI1 = 4'b0010,
    UL_HI_OPEN = 4'b0100,
    UL_LO_OPEN = 4'b1000
  } csw_unlock_t;

  typedef struct packed {
    logic ready;
    logic lock;
  } csw_osc_status_t;

endpackage

`default_nettype wire

// File: rtl/csw_ref_div.sv
// Purpose: Glitch-free reference clock divider with enable.
// Assumes: Source edges arrive as one-cycle ticks synchronous to ref_clk.
// Notes: A divider code of zero passes every tick; code n divides by 2n.

`timescale 1ns/1ps
`default_nettype none

module csw_ref_div
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Control
  input wire logic run,
  input wire logic [3:0] div_sel,
  input wire logic src_tick,
  // Output
  output logic ref_out
);

  logic [3:0] div_q;
  logic [4:0] cnt_q;
  logic [4:0] limit;

  // Code zero toggles on every tick, else toggles after twice div_sel ticks.
  // Doubling keeps code one apart from code zero, so all sixteen ratios differ.
  assign limit = (div_q == 4'h0) ? 5'h01 : {div_q, 1'b0};

  // ==========================================================================
  // The new ratio is only taken at a toggle or while stopped, so no pulse is cut short.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div_q <= 4'h0;
      cnt_q <= 5'h00;
      ref_out <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!run)
      begin
        cnt_q <= 5'h00;
        ref_out <= 1'b0;
        div_q <= div_sel;
      end
      else if (src_tick)
      begin
        if (cnt_q + 5'h01 >= limit)
        begin
          cnt_q <= 5'h00;
          ref_out <= ~ref_out;
          div_q <= div_sel;
        end
        else
        begin
          cnt_q <= cnt_q + 5'h01;
        end
      end
    end
  end

endmodule

`default_nettype wire

// File: rtl/csw_sys_div.sv
// Purpose: Half-rate clock output derived from system clock ticks.
// Assumes: The tick marks each system clock edge in the ref_clk domain.
// Notes: Output is held low when the mode does not present it.

`timescale 1ns/1ps
`default_nettype none

module csw_sys_div
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Control
  input wire logic run,
  input wire logic sys_tick,
  // Output
  output logic half_out
);

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      half_out <= 1'b0;
    end
    else if (clk_en)
    begin
      if (!run)
      begin
        half_out <= 1'b0;
      end
      else if (sys_tick)
      begin
        half_out <= ~half_out;
      end
    end
  end

endmodule

`default_nettype wire

// File: rtl/csw_top.sv
// Purpose: Clock source switch with unlock sequences and reference clock output.
// Assumes: AHB-Lite slave, single word transfers, oscillator ready and PLL lock as inputs.
// Notes: Source edges arrive as ticks synchronous to ref_clk.
//
// How it works
// - High byte unlocks only after 78h then 9Ah on back-to-back writes.
// - New source field loads only on the write right after high unlock.
// - Low byte unlocks only after 46h then 57h on back-to-back writes.
// - Switch enable set right after low unlock starts the switch.
// - Hardware clears switch enable when the switch completes.
// - Switch enable stays set on failure; lock bit shows the cause.
// - Half rate clock pin toggles in certain oscillator modes.
// - Reference output works in every mode via its control register.
// - Bit 15 presents the divided reference clock on its pin.
// - Four-bit field at bits 11:8 selects one of sixteen ratios.
// - Select bit picks primary oscillator or current system clock.
// - Sleep-run bit decides whether reference output runs in Sleep.
// - Sleep running needs sleep-run, select and a primary mode.
// - Without select, primary oscillator powers down in Sleep.
// - With select clear, reference follows the system clock.
//
// Decided for this implementation: the placing of the registers and the AHB-Lite interface to the registers.

`timescale 1ns/1ps
`default_nettype none

module csw_top
(
  // Clock, reset and enable
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Oscillator side
  input wire csw_pkg::csw_osc_status_t osc_status,
  input wire logic primary_osc_tick,
  input wire logic sys_clk_tick,
  input wire logic sleep_mode,
  output logic [2:0] active_source,
  output logic primary_osc_power,
  // Pins
  output logic reference_clock_pin,
  output logic half_rate_clock_pin,
  // Interrupt
  output logic irq
);

  // ==========================================================================
  // Bus address phase capture
  logic wr_pend_q;
  logic rd_pend_q;
  logic [7:0] addr_q;
  logic bus_take;

  assign bus_take = hsel && hready && htrans[1];

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_pend_q <= 1'b0;
      rd_pend_q <= 1'b0;
      addr_q <= 8'h00;
    end
    else if (clk_en)
    begin
      wr_pend_q <= bus_take && hwrite;
      rd_pend_q <= bus_take && !hwrite;
      if (bus_take)
      begin
        addr_q <= haddr[7:0];
      end
    end
  end

  logic wr_osc;
  logic wr_ref;
  logic wr_stat;
  logic wr_mask;
  assign wr_osc = wr_pend_q && (addr_q == csw_pkg::OFS_OSC_CTRL);
  assign wr_ref = wr_pend_q && (addr_q == csw_pkg::OFS_REF_CTRL);
  assign wr_stat = wr_pend_q && (addr_q == csw_pkg::OFS_IRQ_STAT);
  assign wr_mask = wr_pend_q && (addr_q == csw_pkg::OFS_IRQ_MASK);

  // ==========================================================================
  // Unlock sequencer
  // Any oscillator control write that is not the next expected step
  // drops the sequence, so only back-to-back pairs unlock.
  csw_pkg::csw_unlock_t ul_q;
  logic [7:0] wr_hi;
  logic [7:0] wr_lo;
  assign wr_hi = hwdata[15:8];
  assign wr_lo = hwdata[7:0];

  logic ul_lo1_q;
  logic new_source_select_load;
  logic swen_load;
  assign new_source_select_load = wr_osc && (ul_q == csw_pkg::UL_HI_OPEN);
  assign swen_load = wr_osc && (ul_q == csw_pkg::UL_LO_OPEN);

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ul_q <= csw_pkg::UL_NONE;
      ul_lo1_q <= 1'b0;
    end
    else if (clk_en && wr_osc)
    begin
      ul_lo1_q <= (wr_lo == csw_pkg::KEY_LO_1);
      case (ul_q)
        csw_pkg::UL_HI1:
        begin
          if (wr_hi == csw_pkg::KEY_HI_2)
          begin
            ul_q <= csw_pkg::UL_HI_OPEN;
          end
          else
          begin
            ul_q <= csw_pkg::UL_NONE;
          end
        end
        default:
        begin
          if (wr_hi == csw_pkg::KEY_HI_1)
          begin
            ul_q <= csw_pkg::UL_HI1;
          end
          else if (ul_lo1_q && (wr_lo == csw_pkg::KEY_LO_2))
          begin
            ul_q <= csw_pkg::UL_LO_OPEN;
          end
          else
          begin
            ul_q <= csw_pkg::UL_NONE;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Switch engine
  csw_pkg::csw_state_t sw_q;
  logic [2:0] new_source_select_q;
  logic [2:0] cosc_q;
  logic swen_q;
  logic [15:0] tmo_q;
  logic ev_done;
  logic ev_fail;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      new_source_select_q <= csw_pkg::SRC_RST;
    end
    else if (clk_en && new_source_select_load)
    begin
      new_source_select_q <= wr_hi[2:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sw_q <= csw_pkg::SW_IDLE;
      swen_q <= 1'b0;
      cosc_q <= csw_pkg::SRC_RST;
      tmo_q <= 16'h0000;
      ev_done <= 1'b0;
      ev_fail <= 1'b0;
    end
    else if (clk_en)
    begin
      ev_done <= 1'b0;
      ev_fail <= 1'b0;
      case (sw_q)
        csw_pkg::SW_IDLE:
        begin
          if (swen_load && wr_lo[csw_pkg::SWEN_BIT])
          begin
            swen_q <= 1'b1;
            tmo_q <= 16'h0000;
            sw_q <= csw_pkg::SW_WAIT;
          end
        end
        csw_pkg::SW_WAIT:
        begin
          if (osc_status.ready && osc_status.lock)
          begin
            cosc_q <= new_source_select_q;
            swen_q <= 1'b0;
            ev_done <= 1'b1;
            sw_q <= csw_pkg::SW_IDLE;
          end
          else if (tmo_q == 16'(csw_pkg::SWITCH_TIMEOUT_CYC - 1))
          begin
            ev_fail <= 1'b1;
            sw_q <= csw_pkg::SW_FAIL;
          end
          else
          begin
            tmo_q <= tmo_q + 16'h0001;
          end
        end
        csw_pkg::SW_FAIL:
        begin
          // Enable stays set; a late lock still completes the switch.
          if (osc_status.ready && osc_status.lock)
          begin
            cosc_q <= new_source_select_q;
            swen_q <= 1'b0;
            ev_done <= 1'b1;
            sw_q <= csw_pkg::SW_IDLE;
          end
        end
        default:
        begin
          sw_q <= csw_pkg::SW_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Reference output control register
  logic [15:0] ref_ctrl_q;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ref_ctrl_q <= csw_pkg::REF_CTRL_RST;
    end
    else if (clk_en && wr_ref)
    begin
      ref_ctrl_q <= {hwdata[15], 1'b0, hwdata[13:8], 8'h00};
    end
  end

  logic ref_en;
  logic ref_slp;
  logic ref_sel;
  logic pri_mode;
  logic ref_run;
  logic ref_tick;
  assign ref_en = ref_ctrl_q[csw_pkg::REF_EN_BIT];
  assign ref_slp = ref_ctrl_q[csw_pkg::REF_SLP_BIT];
  assign ref_sel = ref_ctrl_q[csw_pkg::REF_SEL_BIT];
  assign pri_mode = (cosc_q == csw_pkg::SRC_PRI_EC) || (cosc_q == csw_pkg::SRC_PRI_XT)
    || (cosc_q == csw_pkg::SRC_PRI_HS);
  // In Sleep the system clock stops, so only the primary path can keep running.
  assign ref_run = ref_en
    && (!sleep_mode || (ref_slp && ref_sel && pri_mode));
  assign ref_tick = ref_sel ? primary_osc_tick : sys_clk_tick;

  csw_ref_div u_ref_div
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .run(ref_run),
    .div_sel(ref_ctrl_q[csw_pkg::REF_DIV_LSB +: csw_pkg::REF_DIV_W]),
    .src_tick(ref_tick),
    .ref_out(reference_clock_pin)
  );

  csw_sys_div u_sys_div
  (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .run(pri_mode && !sleep_mode),
    .sys_tick(sys_clk_tick),
    .half_out(half_rate_clock_pin)
  );

  // ==========================================================================
  // Interrupts: set wins over write-one-to-clear.
  logic [1:0] irq_stat_q;
  logic [1:0] irq_mask_q;
  logic [1:0] irq_set;
  assign irq_set = {ev_fail, ev_done};

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_stat_q <= 2'h0;
      irq_mask_q <= 2'h0;
    end
    else if (clk_en)
    begin
      irq_stat_q <= (irq_stat_q & ~(wr_stat ? hwdata[1:0] : 2'h0)) | irq_set;
      if (wr_mask)
      begin
        irq_mask_q <= hwdata[1:0];
      end
    end
  end

  // ==========================================================================
  // Registered outputs and read data
  logic [31:0] rd_d;

  always_comb
  begin
    rd_d = 32'h0000_0000;
    if (haddr[7:0] == csw_pkg::OFS_OSC_CTRL)
    begin
      rd_d = {16'h0000, 1'b0, cosc_q, 1'b0, new_source_select_q, 7'h00, swen_q};
    end
    else if (haddr[7:0] == csw_pkg::OFS_REF_CTRL)
    begin
      rd_d = {16'h0000, ref_ctrl_q};
    end
    else if (haddr[7:0] == csw_pkg::OFS_IRQ_STAT)
    begin
      rd_d = {30'h0000_0000, irq_stat_q};
    end
    else if (haddr[7:0] == csw_pkg::OFS_IRQ_MASK)
    begin
      rd_d = {30'h0000_0000, irq_mask_q};
    end
    else if (haddr[7:0] == csw_pkg::OFS_OSC_STAT)
    begin
      rd_d = {30'h0000_0000, osc_status.ready, osc_status.lock};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      irq <= 1'b0;
      active_source <= csw_pkg::SRC_RST;
      primary_osc_power <= 1'b1;
    end
    else if (clk_en)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (bus_take && !hwrite)
      begin
        hrdata <= rd_d;
      end
      irq <= |(irq_stat_q & irq_mask_q);
      active_source <= cosc_q;
      primary_osc_power <= !sleep_mode || ref_sel;
    end
  end

endmodule

`default_nettype wire

// File: verification/csw_top_chk.sv
// Purpose: Port-level checks for the clock switch and reference output block.
// Assumes: Only the top module's ports are seen; control fields are shadowed from bus writes.
// Notes: Shadows update at the data-phase edge, the same edge as the registers.
`timescale 1ns/1ps
`default_nettype none
module csw_top_chk
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // Oscillator side and pins
  input wire csw_pkg::csw_osc_status_t osc_status,
  input wire logic primary_osc_tick,
  input wire logic sys_clk_tick,
  input wire logic sleep_mode,
  input wire logic [2:0] active_source,
  input wire logic primary_osc_power,
  input wire logic reference_clock_pin,
  input wire logic half_rate_clock_pin,
  input wire logic irq
);
  logic take;
  logic ref_wr_q;
  logic mask_wr_q;
  logic [15:0] ref_q;
  logic [1:0] mask_q;
  assign take = hsel && hready && htrans[1] && hwrite && clk_en;
  // ==========================================================================
  // Shadow registers
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ref_wr_q <= 1'h0;
      mask_wr_q <= 1'h0;
      ref_q <= csw_pkg::REF_CTRL_RST;
      mask_q <= 2'h0;
    end
    else if (clk_en)
    begin
      ref_wr_q <= take && (haddr[7:0] == csw_pkg::OFS_REF_CTRL);
      mask_wr_q <= take && (haddr[7:0] == csw_pkg::OFS_IRQ_MASK);
      if (ref_wr_q)
        ref_q <= hwdata[15:0];
      if (mask_wr_q)
        mask_q <= hwdata[1:0];
    end
  end
  // ==========================================================================
  // Assertions
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  sequence s_ref_off;
    (!ref_q[csw_pkg::REF_EN_BIT] && clk_en) [*3];
  endsequence
  sequence s_sleep_stop;
    (sleep_mode && !ref_q[csw_pkg::REF_SLP_BIT]) [*4];
  endsequence
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus answer not ready or not okay");
  a_src_cause: assert property ($changed(active_source) |->
    $past(osc_status.ready && osc_status.lock, 2))
    else $error("source changed without ready and lock");
  a_ref_off: assert property (s_ref_off |-> !reference_clock_pin)
    else $error("reference pin active while disabled");
  a_ref_tick: assert property ($rose(reference_clock_pin) |->
    ($past(ref_q[csw_pkg::REF_SEL_BIT]) ?
    ($past(primary_osc_tick) || $past(primary_osc_tick, 2)) :
    ($past(sys_clk_tick) || $past(sys_clk_tick, 2))))
    else $error("reference pin rose without a tick of its source");
  a_half_tick: assert property ($rose(half_rate_clock_pin) |->
    ($past(sys_clk_tick) || $past(sys_clk_tick, 2)))
    else $error("half rate pin rose without a system tick");
  a_sleep_stop: assert property (s_sleep_stop |-> $stable(reference_clock_pin))
    else $error("reference pin moved in sleep without sleep run");
  a_pwr_follow: assert property ($past(clk_en) |-> primary_osc_power ==
    !$past(sleep_mode && !ref_q[csw_pkg::REF_SEL_BIT]))
    else $error("primary oscillator power wrong");
  a_irq_masked: assert property ((mask_q == 2'h0) [*2] |-> !irq)
    else $error("interrupt high with all sources masked");
endmodule
bind csw_top csw_top_chk u_chk (.ref_clk, .rst_n, .clk_en, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hreadyout, .hresp, .osc_status, .primary_osc_tick, .sys_clk_tick,
  .sleep_mode, .active_source, .primary_osc_power, .reference_clock_pin,
  .half_rate_clock_pin, .irq);
`default_nettype wire

// File: verification/tb.sv
// Purpose: Self-checking bench for the clock switch and reference output block.
// Assumes: Primary ticks every 3 cycles, system ticks every 4 cycles.
// Notes: Toggle counts allow one edge of phase slack in a 240-cycle window.
`timescale 1ns/1ps
`default_nettype none
module tb;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e; int tog;} csw_row_t;
  localparam logic [7:0] OSC = csw_pkg::OFS_OSC_CTRL;
  localparam logic [7:0] REF = csw_pkg::OFS_REF_CTRL;
  localparam logic [7:0] IST = csw_pkg::OFS_IRQ_STAT;
  localparam logic [7:0] MSK = csw_pkg::OFS_IRQ_MASK;
  logic ref_clk = 1'h0, rst_n = 1'h0, clk_en = 1'h1, hsel = 1'h0, hwrite = 1'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2, active_source;
  logic hreadyout, hresp, primary_osc_power, reference_clock_pin, half_rate_clock_pin, irq;
  logic primary_osc_tick = 1'h0, sys_clk_tick = 1'h0, sleep_mode = 1'h0;
  csw_pkg::csw_osc_status_t osc_status = 2'h0;
  wire logic hready;
  int fail_count = 0, check_count = 0, tcnt = 0, nr, nh;
  logic [31:0] r;
  logic [15:0] bad_seq [8] = '{16'h7800, 16'h0000, 16'h9A00, 16'h0500,
                               16'h0046, 16'h0000, 16'h0057, 16'h0001};
  csw_row_t rows [10] = '{'{REF, 32'h0, 32'h0, 0}, '{REF, 32'h9000, 32'h9000, 80},
    '{REF, 32'h9400, 32'h9400, 10}, '{REF, 32'h8200, 32'h8200, 15},
    '{REF, 32'h9800, 32'h9800, 5}, '{MSK, 32'h3, 32'h3, 5}, '{IST, 32'h3, 32'h0, 5},
    '{8'h14, 32'hFFFF, 32'h0, 5}, '{OSC, 32'h0701, 32'h0, 5}, '{REF, 32'h0800, 32'h0800, 0}};
  assign hready = hreadyout;
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    tcnt <= tcnt + 1;
    primary_osc_tick <= (tcnt % 3 == 0);
    sys_clk_tick <= (tcnt % 4 == 0);
  end
  csw_top dut (.ref_clk, .rst_n, .clk_en, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hrdata, .hreadyout, .hresp, .osc_status, .primary_osc_tick, .sys_clk_tick,
    .sleep_mode, .active_source, .primary_osc_power, .reference_clock_pin,
    .half_rate_clock_pin, .irq);
  // ==========================================================================
  // Bus and compare tasks
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    @(posedge ref_clk);
    while (hreadyout !== 1'h1) @(posedge ref_clk);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge ref_clk);
    while (hreadyout !== 1'h1) @(posedge ref_clk);
    r = hrdata;
  endtask
  task automatic chk_val(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_cnt(input string n, input int e, input int g);
    check_count++;
    if (g > e + 1 || g < e - 1)
    begin
      fail_count++;
      $display("[FAIL] %s expected %0d seen %0d", n, e, g);
    end
  endtask
  task automatic rd_chk(input string n, input logic [7:0] a, input logic [31:0] e);
    xfer(1'h0, a, 32'h0);
    chk_val(n, e, r);
  endtask
  task automatic count_tog();
    logic pr, ph;
    nr = 0;
    nh = 0;
    repeat (240)
    begin
      pr = reference_clock_pin;
      ph = half_rate_clock_pin;
      @(posedge ref_clk);
      #1;
      nr += (reference_clock_pin !== pr);
      nh += (half_rate_clock_pin !== ph);
    end
  endtask
  task automatic switch_to(input logic [2:0] s);
    xfer(1'h1, OSC, 32'h7800);
    xfer(1'h1, OSC, 32'h9A00);
    xfer(1'h1, OSC, {21'h0, s, 8'h00});
    xfer(1'h1, OSC, 32'h0046);
    xfer(1'h1, OSC, 32'h0057);
    xfer(1'h1, OSC, 32'h0001);
  endtask
  task automatic reset_chk();
    @(posedge ref_clk);
    rst_n <= 1'h0;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'h1;
    #1;
    chk_val("pins after reset", 32'h8, {25'h0, active_source, primary_osc_power, irq,
      reference_clock_pin, half_rate_clock_pin});
    rd_chk("osc ctrl reset", OSC, 32'h0);
    rd_chk("ref ctrl reset", REF, {16'h0, csw_pkg::REF_CTRL_RST});
    rd_chk("irq status reset", IST, 32'h0);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial
  begin
    repeat (30000) @(posedge ref_clk);
    fail_count++;
    end_sim();
  end
  // ==========================================================================
  // Main sequence
  initial
  begin
    reset_chk();
    count_tog();
    chk_cnt("half rate idle", 0, nh);
    foreach (rows[i])
    begin
      xfer(1'h1, rows[i].a, rows[i].d);
      rd_chk("row readback", rows[i].a, rows[i].e);
      repeat (40) @(posedge ref_clk);
      count_tog();
      chk_cnt("reference toggles", rows[i].tog, nr);
    end
    switch_to(3'h3);
    rd_chk("switch pending", OSC, 32'h0301);
    osc_status <= 2'h3;
    repeat (8) @(posedge ref_clk);
    rd_chk("switch done", OSC, 32'h3300);
    chk_val("active source", 32'h3, {29'h0, active_source});
    rd_chk("done status", IST, 32'h1);
    chk_val("irq raised", 32'h1, {31'h0, irq});
    xfer(1'h1, MSK, 32'h0);
    repeat (4) @(posedge ref_clk);
    chk_val("irq masked", 32'h0, {31'h0, irq});
    xfer(1'h1, MSK, 32'h3);
    xfer(1'h1, IST, 32'h1);
    repeat (4) @(posedge ref_clk);
    chk_val("irq cleared", 32'h0, {31'h0, irq});
    foreach (bad_seq[i]) xfer(1'h1, OSC, {16'h0, bad_seq[i]});
    rd_chk("broken unlock", OSC, 32'h3300);
    count_tog();
    chk_cnt("half rate", 60, nh);
    xfer(1'h1, REF, 32'h9000);
    sleep_mode <= 1'h1;
    repeat (10) @(posedge ref_clk);
    count_tog();
    chk_cnt("sleep no run", 0, nr);
    chk_val("power kept", 32'h1, {31'h0, primary_osc_power});
    xfer(1'h1, REF, 32'hB000);
    repeat (40) @(posedge ref_clk);
    count_tog();
    chk_cnt("sleep run", 80, nr);
    xfer(1'h1, REF, 32'hA000);
    count_tog();
    chk_cnt("sleep system source", 0, nr);
    chk_val("power down", 32'h0, {31'h0, primary_osc_power});
    sleep_mode <= 1'h0;
    osc_status <= 2'h0;
    switch_to(3'h2);
    repeat (csw_pkg::SWITCH_TIMEOUT_CYC + 20) @(posedge ref_clk);
    rd_chk("switch failed", OSC, 32'h3201);
    rd_chk("lock status", csw_pkg::OFS_OSC_STAT, 32'h0);
    rd_chk("fail status", IST, 32'h2);
    chk_val("irq on fail", 32'h1, {31'h0, irq});
    reset_chk();
    end_sim();
  end
endmodule
`default_nettype wire
